// ---- pkg/fsfd_pkg.sv ----
package fsfd_pkg;
	localparam int unsigned DEPTH      = 64;
	localparam int unsigned PTR_W      = 6;
	localparam int unsigned CNT_W      = 7;
	localparam logic [6:0]  CNT_FULL   = 7'h40;
	localparam logic [6:0]  CNT_ZERO   = 7'h00;
	localparam logic [2:0]  BIT_LAST   = 3'h7;
	localparam logic [2:0]  BIT_FIRST  = 3'h0;
	// AHB byte addresses
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_STATUS   = 8'h04;
	localparam logic [7:0]  A_DATA     = 8'h08;
	localparam logic [7:0]  A_THRESH   = 8'h0c;
	localparam logic [7:0]  A_PCFG     = 8'h10;
	localparam logic [7:0]  A_PVAL_LO  = 8'h14;
	localparam logic [7:0]  A_PVAL_HI  = 8'h18;
	localparam logic [7:0]  A_PLIMIT   = 8'h1c;
	// Payload bounds
	localparam logic [11:0] LIMIT_255  = 12'h0ff;
	localparam logic [11:0] LIMIT_2047 = 12'h7ff;
	// Status bits
	localparam int unsigned ST_DRAINED = 0;
	localparam int unsigned ST_FULL    = 1;
	localparam int unsigned ST_LEVEL   = 2;
	localparam int unsigned ST_OVF     = 3;
	localparam int unsigned ST_TXDONE  = 4;
	localparam int unsigned ST_MATCH   = 5;
	localparam int unsigned ST_SETTLED = 6;

	typedef enum logic [1:0] {
		FSFD_SLEEP = 2'b00,
		FSFD_STDBY = 2'b01,
		FSFD_RX    = 2'b10,
		FSFD_TX    = 2'b11
	} fsfd_mode_e;

	typedef enum logic [1:0] {
		FSFD_LIM_255  = 2'b00,
		FSFD_LIM_2047 = 2'b01,
		FSFD_LIM_NONE = 2'b10,
		FSFD_LIM_RSV  = 2'b11
	} fsfd_limit_e;

	typedef struct packed {
		logic drained;
		logic full;
		logic level;
		logic ovf;
		logic tx_done;
		logic match;
		logic settled;
	} fsfd_status_s;
endpackage : fsfd_pkg

// ---- hw/fsfd_datapath.sv ----
// Summary of operation
// - Continuous mode passes bits on serial data pin, bypassing the queue.
// - Packet mode: frame builder strips framing, only payload enters queue.
// - Payload length bounded at 255, 2047 or unbounded by limit select.
// - Queue is one byte wide, 64 deep, whole-byte transfers only.
// - Packet data in both directions lives in queue, host uses the bus.
// - Transmit shifter sends queue bytes MSB first at bit-rate edges.
// - Receive shifter assembles bits and writes each full byte to queue.
// - Mode-settled flag set at once, except later when leaving transmit.
// - Drained indication high when queue holds no bytes, rising one cycle after the last pop.
// - Drained indication refreshed at start of each host access.
// - Full indication high exactly when all 64 positions occupied.
// - Write into full queue drops byte, sets overflow; write 1 clears both.
// - Transmit-done raised when shifter's final bit has left and the queue is empty.
// - Level flag re-evaluated only on queue read or write.
// - Level flag invalid after full, resumes after queue fully empties.
// - Queue emptied entering receive, receive to transmit, leaving transmit.
// - Queue kept across standby/sleep, standby/sleep into transmit, receive to idle.
// - Pattern detection runs only when enabled; in continuous mode also only when bits are synchronised.
// - Pattern compared continuously in a shift register, sets match flag.
// - First received bit meets bit 7 of first pattern byte.
// - Match flag cleared leaving receive or when queue emptied.
// - Pattern length selects 1 to 8 bytes, used only by the receive compare.
`timescale 1ns/1ns
`default_nettype none
module fsfd_datapath (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        bit_clk_i,
	input  wire logic        rx_bit_i,
	input  wire logic        bit_sync_lock_i,
	output logic             tx_bit_o,
	input  wire logic        serial_data_pin_i,
	output logic             serial_data_pin_o,
	output logic             serial_data_pin_oe_o,
	input  wire logic        tx_exit_done_i,
	output logic             mode_change_o,
	output logic             queue_drained_o,
	output logic             queue_full_flag_o,
	output logic             queue_level_flag_o,
	output logic             frame_tx_done_o,
	output logic             pattern_match_flag_o,
	output logic             mode_settled_flag_o
);
	// Registers
	logic [31:0]               hrdata_r;
	logic                      ctrl_packet_r;
	fsfd_pkg::fsfd_mode_e      mode_r;
	logic [5:0]                thresh_r;
	logic                      pattern_detect_enable;
	logic [2:0]                pattern_length_field;
	logic [63:0]               pattern_value_field;
	fsfd_pkg::fsfd_limit_e     limit_sel_r;
	logic [7:0]                mem_r [fsfd_pkg::DEPTH];
	logic [5:0]                wptr_r;
	logic [5:0]                rptr_r;
	logic [6:0]                cnt_r;
	logic                      full_r;
	logic                      queue_overflow_flag;
	logic                      level_r;
	logic                      level_valid_r;
	logic                      drained_r;
	logic                      txdone_r;
	logic                      match_r;
	logic                      settled_r;
	logic                      tx_bit_r;
	logic                      pin_o_r;
	logic                      pin_oe_r;
	logic                      mchg_r;
	logic [2:0]                bclk_s;
	logic [1:0]                rxb_s;
	logic [1:0]                pin_s;
	logic [1:0]                lock_s;
	logic [1:0]                exit_s;
	logic [7:0]                tx_shift_r;
	logic [2:0]                tx_cnt_r;
	logic                      tx_busy_r;
	logic [7:0]                rx_shift_r;
	logic [2:0]                rx_cnt_r;
	logic [63:0]               pat_hist_r;
	logic [11:0]               pay_cnt_r;
	logic                      pend_r;
	logic                      pend_wr_r;
	logic [7:0]                pend_addr_r;
	logic                      settle_wait_r;

	// Bus decode
	logic        acc;
	logic        bus_wr;
	logic        bus_rd;
	logic        host_push;
	logic        host_pop;
	logic        sh_push;
	logic        sh_pop;
	logic        push;
	logic        pop;
	logic        flush;
	logic        ovf_clr;
	logic        mode_wr;
	logic        bit_edge;
	logic        rx_bit;
	logic        sync_ok;
	logic        lim_hit;
	logic [63:0] pat_mask;
	fsfd_pkg::fsfd_mode_e new_mode;

	assign acc      = hsel & hready & htrans[1];
	assign bus_wr   = pend_r & pend_wr_r;
	assign bus_rd   = pend_r & ~pend_wr_r;
	assign new_mode = fsfd_pkg::fsfd_mode_e'(hwdata[2:1]);
	assign mode_wr  = bus_wr & (pend_addr_r == fsfd_pkg::A_CTRL);
	assign ovf_clr  = bus_wr & (pend_addr_r == fsfd_pkg::A_STATUS) & hwdata[fsfd_pkg::ST_OVF];
	assign bit_edge = bclk_s[1] & ~bclk_s[2];
	assign rx_bit   = rxb_s[1];
	assign sync_ok  = ~ctrl_packet_r ? lock_s[1] : 1'b1;

	always_comb
	begin
		flush = ovf_clr;
		if (mode_wr && new_mode != mode_r)
		begin
			if (mode_r == fsfd_pkg::FSFD_TX)
				flush = 1'b1;
			if (new_mode == fsfd_pkg::FSFD_RX)
				flush = 1'b1;
			if (mode_r == fsfd_pkg::FSFD_RX && new_mode == fsfd_pkg::FSFD_TX)
				flush = 1'b1;
		end
	end

	// Host may write in packet mode in standby/transmit/sleep, never in receive
	assign host_push = bus_wr & (pend_addr_r == fsfd_pkg::A_DATA) & ctrl_packet_r
		& (mode_r != fsfd_pkg::FSFD_RX);
	assign host_pop  = bus_rd & (pend_addr_r == fsfd_pkg::A_DATA) & (cnt_r != fsfd_pkg::CNT_ZERO);

	always_comb
	begin
		unique case (limit_sel_r)
			fsfd_pkg::FSFD_LIM_255:  lim_hit = (pay_cnt_r >= fsfd_pkg::LIMIT_255);
			fsfd_pkg::FSFD_LIM_2047: lim_hit = (pay_cnt_r >= fsfd_pkg::LIMIT_2047);
			default:                 lim_hit = 1'b0;
		endcase
	end

	assign sh_push = ctrl_packet_r & (mode_r == fsfd_pkg::FSFD_RX) & bit_edge & match_r
		& (rx_cnt_r == fsfd_pkg::BIT_LAST) & ~lim_hit;
	assign sh_pop  = ctrl_packet_r & (mode_r == fsfd_pkg::FSFD_TX) & ~tx_busy_r
		& (cnt_r != fsfd_pkg::CNT_ZERO) & ~host_pop;
	assign push    = (host_push | sh_push) & (cnt_r != fsfd_pkg::CNT_FULL) & ~flush;
	assign pop     = (host_pop | sh_pop) & ~flush;

	// Pattern mask: length field keeps the low (len+1) bytes of the compare
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_mask
			assign pat_mask[gi*8 +: 8] = (3'(gi) <= pattern_length_field) ? 8'hff : 8'h00;
		end
	endgenerate

	// Synchronisers
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bclk_s <= 3'h0;
			rxb_s  <= 2'h0;
			pin_s  <= 2'h0;
			lock_s <= 2'h0;
			exit_s <= 2'h0;
		end
		else
		begin
			bclk_s <= {bclk_s[1:0], bit_clk_i};
			rxb_s  <= {rxb_s[0], rx_bit_i};
			pin_s  <= {pin_s[0], serial_data_pin_i};
			lock_s <= {lock_s[0], bit_sync_lock_i};
			exit_s <= {exit_s[0], tx_exit_done_i};
		end
	end

	// AHB-Lite slave, zero wait states
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pend_r      <= 1'b0;
			pend_wr_r   <= 1'b0;
			pend_addr_r <= 8'h00;
		end
		else
		begin
			pend_r      <= acc;
			pend_wr_r   <= hwrite;
			pend_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hrdata_r <= 32'h0000_0000;
		else if (acc && !hwrite)
		begin
			unique case (haddr[7:0])
				fsfd_pkg::A_CTRL:    hrdata_r <= {29'h0, mode_r, ctrl_packet_r};
				fsfd_pkg::A_STATUS:  hrdata_r <= {25'h0, settled_r, match_r, txdone_r,
					queue_overflow_flag, level_r, queue_full_flag_o, drained_r};
				// Back-to-back reads: skip the byte that is being popped now
				fsfd_pkg::A_DATA:    hrdata_r <= {24'h0, mem_r[pop ? rptr_r + 6'h01 : rptr_r]};
				fsfd_pkg::A_THRESH:  hrdata_r <= {26'h0, thresh_r};
				fsfd_pkg::A_PCFG:    hrdata_r <= {28'h0, pattern_detect_enable, pattern_length_field};
				fsfd_pkg::A_PVAL_LO: hrdata_r <= pattern_value_field[31:0];
				fsfd_pkg::A_PVAL_HI: hrdata_r <= pattern_value_field[63:32];
				fsfd_pkg::A_PLIMIT:  hrdata_r <= {30'h0, limit_sel_r};
				default:             hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_packet_r         <= 1'b1;
			mode_r                <= fsfd_pkg::FSFD_STDBY;
			thresh_r              <= 6'h0f;
			pattern_detect_enable <= 1'b1;
			pattern_length_field  <= 3'h3;
			pattern_value_field   <= 64'h0101_0101_0101_0101;
			limit_sel_r           <= fsfd_pkg::FSFD_LIM_255;
		end
		else if (bus_wr)
		begin
			unique case (pend_addr_r)
				fsfd_pkg::A_CTRL:
				begin
					ctrl_packet_r <= hwdata[0];
					mode_r        <= new_mode;
				end
				fsfd_pkg::A_THRESH: thresh_r <= hwdata[5:0];
				fsfd_pkg::A_PCFG:
				begin
					pattern_length_field  <= hwdata[2:0];
					pattern_detect_enable <= hwdata[3];
				end
				fsfd_pkg::A_PVAL_LO: pattern_value_field[31:0]  <= hwdata;
				fsfd_pkg::A_PVAL_HI: pattern_value_field[63:32] <= hwdata;
				fsfd_pkg::A_PLIMIT:  limit_sel_r <= fsfd_pkg::fsfd_limit_e'(hwdata[1:0]);
				default:
				begin
				end
			endcase
		end
	end

	// Queue storage and pointers
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_r[wptr_r] <= host_push ? hwdata[7:0] : {rx_shift_r[6:0], rx_bit};
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wptr_r <= 6'h00;
			rptr_r <= 6'h00;
			cnt_r  <= fsfd_pkg::CNT_ZERO;
			full_r <= 1'b0;
		end
		else if (flush)
		begin
			wptr_r <= 6'h00;
			rptr_r <= 6'h00;
			cnt_r  <= fsfd_pkg::CNT_ZERO;
			full_r <= 1'b0;
		end
		else
		begin
			if (push)
				wptr_r <= wptr_r + 6'h01;
			if (pop)
				rptr_r <= rptr_r + 6'h01;
			if (push && !pop)
			begin
				cnt_r  <= cnt_r + 7'h01;
				full_r <= (cnt_r == fsfd_pkg::CNT_FULL - 7'h01);
			end
			else if (pop && !push)
			begin
				cnt_r  <= cnt_r - 7'h01;
				full_r <= 1'b0;
			end
		end
	end

	// Overflow: the clearing write wins over a new overrun in the same cycle
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			queue_overflow_flag <= 1'b0;
		else if ((host_push || sh_push) && cnt_r == fsfd_pkg::CNT_FULL && !flush)
			queue_overflow_flag <= 1'b1;
		else if (ovf_clr)
			queue_overflow_flag <= 1'b0;
	end

	// Drained follows the count; it moves at access start, on push or flush,
	// and whenever the count is zero, so it rises the cycle after the last pop
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			drained_r <= 1'b1;
		else if (acc || flush || push || cnt_r == fsfd_pkg::CNT_ZERO)
			drained_r <= (cnt_r == fsfd_pkg::CNT_ZERO) & ~push | flush;
	end

	// Level compare only on queue traffic; full suspends it until empty
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			level_r       <= 1'b0;
			level_valid_r <= 1'b1;
		end
		else if (flush)
		begin
			level_r       <= 1'b0;
			level_valid_r <= 1'b1;
		end
		else if (push || pop)
		begin
			if (push && !pop && cnt_r == fsfd_pkg::CNT_FULL - 7'h01)
				level_valid_r <= 1'b0;
			else if (pop && !push && cnt_r == 7'h01)
				level_valid_r <= 1'b1;
			if (level_valid_r || (pop && !push && cnt_r == 7'h01))
				level_r <= ((push && !pop) ? cnt_r + 7'h01 :
					(pop && !push) ? cnt_r - 7'h01 : cnt_r) > {1'b0, thresh_r};
		end
	end

	// Transmit shifter
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tx_shift_r <= 8'h00;
			tx_cnt_r   <= fsfd_pkg::BIT_FIRST;
			tx_busy_r  <= 1'b0;
			tx_bit_r   <= 1'b0;
			txdone_r   <= 1'b0;
		end
		else
		begin
			// Mode write clears first, so a last bit in that cycle still wins
			if (mode_wr)
				txdone_r <= 1'b0;
			if (sh_pop)
			begin
				tx_shift_r <= mem_r[rptr_r];
				tx_cnt_r   <= fsfd_pkg::BIT_FIRST;
				tx_busy_r  <= 1'b1;
				txdone_r   <= 1'b0;
			end
			else if (tx_busy_r && bit_edge)
			begin
				tx_bit_r   <= tx_shift_r[7];
				tx_shift_r <= {tx_shift_r[6:0], 1'b0};
				tx_cnt_r   <= tx_cnt_r + 3'h1;
				if (tx_cnt_r == fsfd_pkg::BIT_LAST)
				begin
					tx_busy_r <= 1'b0;
					txdone_r  <= (cnt_r == fsfd_pkg::CNT_ZERO);
				end
			end
			else if (!ctrl_packet_r && mode_r == fsfd_pkg::FSFD_TX && bit_edge)
				tx_bit_r <= pin_s[1];
		end
	end

	// Receive shifter, pattern history and payload count
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_shift_r <= 8'h00;
			rx_cnt_r   <= fsfd_pkg::BIT_FIRST;
			pat_hist_r <= 64'h0;
			match_r    <= 1'b0;
			pay_cnt_r  <= 12'h000;
		end
		else if (flush || mode_r != fsfd_pkg::FSFD_RX || (mode_wr && new_mode != mode_r))
		begin
			rx_cnt_r   <= fsfd_pkg::BIT_FIRST;
			pat_hist_r <= 64'h0;
			match_r    <= 1'b0;
			pay_cnt_r  <= 12'h000;
		end
		else if (bit_edge && sync_ok)
		begin
			pat_hist_r <= {pat_hist_r[62:0], rx_bit};
			if (!match_r && pattern_detect_enable &&
				(({pat_hist_r[62:0], rx_bit} ^ (pattern_value_field >>
				{pattern_length_field ^ 3'h7, 3'h0})) & pat_mask) == 64'h0)
			begin
				match_r  <= 1'b1;
				rx_cnt_r <= fsfd_pkg::BIT_FIRST;
			end
			else if (match_r)
			begin
				rx_shift_r <= {rx_shift_r[6:0], rx_bit};
				rx_cnt_r   <= rx_cnt_r + 3'h1;
				if (rx_cnt_r == fsfd_pkg::BIT_LAST && !lim_hit)
					pay_cnt_r <= pay_cnt_r + 12'h001;
			end
		end
	end

	// Mode change, settle flag, pins
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			settled_r     <= 1'b1;
			settle_wait_r <= 1'b0;
			mchg_r        <= 1'b0;
			pin_o_r       <= 1'b0;
			pin_oe_r      <= 1'b0;
		end
		else
		begin
			mchg_r <= mode_wr && new_mode != mode_r;
			if (mode_wr && new_mode != mode_r)
			begin
				settle_wait_r <= (mode_r == fsfd_pkg::FSFD_TX);
				settled_r     <= (mode_r != fsfd_pkg::FSFD_TX);
			end
			else if (settle_wait_r && exit_s[1])
			begin
				settle_wait_r <= 1'b0;
				settled_r     <= 1'b1;
			end
			pin_oe_r <= ~ctrl_packet_r & (mode_r == fsfd_pkg::FSFD_RX);
			if (bit_edge)
				pin_o_r <= rx_bit;
		end
	end

	assign hrdata               = hrdata_r;
	assign hreadyout            = 1'b1;
	assign hresp                = 1'b0;
	assign tx_bit_o             = tx_bit_r;
	assign serial_data_pin_o    = pin_o_r;
	assign serial_data_pin_oe_o = pin_oe_r;
	assign mode_change_o        = mchg_r;
	assign queue_drained_o      = drained_r;
	assign queue_full_flag_o    = full_r;
	assign queue_level_flag_o   = level_r;
	assign frame_tx_done_o      = txdone_r;
	assign pattern_match_flag_o = match_r;
	assign mode_settled_flag_o  = settled_r;
endmodule : fsfd_datapath
`default_nettype wire

// ---- tb/fsfd_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module fsfd_props (
	input wire logic        clk_sys_i,
	input wire logic        reset_n_i,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        tx_exit_done_i,
	input wire logic        mode_change_o,
	input wire logic        queue_drained_o,
	input wire logic        queue_full_flag_o,
	input wire logic        frame_tx_done_o,
	input wire logic        mode_settled_flag_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	logic stat_wr_r;
	// Marks the data phase of a status write
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
			stat_wr_r <= 1'b0;
		else
			stat_wr_r <= hsel && hready && htrans[1] && hwrite
				&& haddr[7:0] == fsfd_pkg::A_STATUS;
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready)
		else $error("slave stalled the bus");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay)
		else $error("slave gave an error response");
	property p_rdata; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data moved without a read");
	property p_excl; !(queue_full_flag_o && queue_drained_o); endproperty
	a_excl: assert property (p_excl)
		else $error("queue full and drained at once");
	property p_flush; stat_wr_r && hwdata[3] |-> ##[1:3] queue_drained_o; endproperty
	a_flush: assert property (p_flush)
		else $error("overflow clear did not empty the queue");
	property p_txdone; $rose(frame_tx_done_o) |-> queue_drained_o; endproperty
	a_txdone: assert property (p_txdone)
		else $error("transmit done while bytes remain");
	property p_mc; mode_change_o |=> !mode_change_o; endproperty
	a_mc: assert property (p_mc)
		else $error("mode change pulse too long");
	property p_settle; !mode_settled_flag_o && tx_exit_done_i |-> ##[0:3] mode_settled_flag_o;
	endproperty
	a_settle: assert property (p_settle)
		else $error("settled flag late after transmit exit");
endmodule : fsfd_props
bind fsfd_datapath fsfd_props u_props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.tx_exit_done_i(tx_exit_done_i), .mode_change_o(mode_change_o),
	.queue_drained_o(queue_drained_o), .queue_full_flag_o(queue_full_flag_o),
	.frame_tx_done_o(frame_tx_done_o), .mode_settled_flag_o(mode_settled_flag_o));
`default_nettype wire

// ---- tb/fsfd_modem.sv ----
`timescale 1ns/1ns
`default_nettype none
module fsfd_modem (
	output logic      bit_clk_o,
	output logic      rx_bit_o,
	input  wire logic tx_bit_i
);
	logic [63:0] cap_r;
	initial
	begin
		bit_clk_o = 1'b0;
		rx_bit_o  = 1'b0;
		cap_r     = 64'h0;
	end
	// Clock stands still between frames; line turns to junk once released
	task automatic run(input logic [63:0] bits, input int n);
		#3;
		for (int i = n - 1; i >= 0; i--)
		begin
			rx_bit_o = bits[i];
			#80 bit_clk_o = 1'b1;
			#80 bit_clk_o = 1'b0;
			cap_r = {cap_r[62:0], tx_bit_i};
		end
		rx_bit_o = ~rx_bit_o;
	endtask : run
endmodule : fsfd_modem
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
	logic                  clk_sys_i;
	logic                  reset_n_i;
	logic                  hsel;
	logic [31:0]           haddr;
	logic [1:0]            htrans;
	logic                  hwrite;
	logic [31:0]           hwdata;
	logic [31:0]           hrdata;
	logic                  hreadyout;
	logic                  hresp;
	logic                  bit_clk;
	logic                  rx_bit;
	logic                  sync_lock;
	logic                  tx_bit;
	logic                  pin_o;
	logic                  pin_oe;
	logic                  pin_in;
	logic                  tx_exit_done;
	logic                  mode_change;
	fsfd_pkg::fsfd_status_s st;
	logic [31:0]           rdata;
	logic                  found;
	int                    num_errors;
	int                    compares;
	fsfd_datapath dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.bit_clk_i(bit_clk), .rx_bit_i(rx_bit), .bit_sync_lock_i(sync_lock),
		.tx_bit_o(tx_bit), .serial_data_pin_i(pin_in), .serial_data_pin_o(pin_o),
		.serial_data_pin_oe_o(pin_oe), .tx_exit_done_i(tx_exit_done),
		.mode_change_o(mode_change), .queue_drained_o(st.drained),
		.queue_full_flag_o(st.full), .queue_level_flag_o(st.level),
		.frame_tx_done_o(st.tx_done), .pattern_match_flag_o(st.match),
		.mode_settled_flag_o(st.settled));
	fsfd_modem modem (.bit_clk_o(bit_clk), .rx_bit_o(rx_bit), .tx_bit_i(tx_bit));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	task automatic conclude;
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h0, a};
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask : bus
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wt
	task automatic t_reset;
		`CHK("drained pin", 1'b1, st.drained)
		bus(1'b0, fsfd_pkg::A_STATUS, 32'h0);
		`CHK("status", 32'h41, rdata)
		bus(1'b0, fsfd_pkg::A_THRESH, 32'h0);
		`CHK("threshold", 6'h0f, rdata[5:0])
		bus(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rdata)
	endtask : t_reset
	task automatic t_fill;
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h3);
		bus(1'b1, fsfd_pkg::A_THRESH, 32'h2);
		for (int i = 0; i < 64; i++)
		begin
			bus(1'b1, fsfd_pkg::A_DATA, {24'h0, i[7:0]});
			wt(3);
			if (i == 1) `CHK("level 2", 1'b0, st.level)
			if (i == 2)
			begin
				`CHK("level 3", 1'b1, st.level)
				bus(1'b1, fsfd_pkg::A_THRESH, 32'h5);
				wt(3);
				`CHK("level kept", 1'b1, st.level)
			end
			if (i == 3) `CHK("level 4", 1'b0, st.level)
			if (i == 62) `CHK("full 63", 1'b0, st.full)
		end
		`CHK("full 64", 1'b1, st.full)
		bus(1'b1, fsfd_pkg::A_DATA, 32'hee);
		bus(1'b0, fsfd_pkg::A_STATUS, 32'h0);
		`CHK("overflow", 1'b1, rdata[fsfd_pkg::ST_OVF])
		bus(1'b0, fsfd_pkg::A_DATA, 32'h0);
		`CHK("first byte", 8'h00, rdata[7:0])
		wt(3);
		`CHK("full after pop", 1'b0, st.full)
		bus(1'b1, fsfd_pkg::A_STATUS, 32'h8);
		wt(3);
		`CHK("flushed", 1'b1, st.drained)
		bus(1'b0, fsfd_pkg::A_STATUS, 32'h0);
		`CHK("overflow clear", 1'b0, rdata[fsfd_pkg::ST_OVF])
	endtask : t_fill
	task automatic t_clear;
		bus(1'b1, fsfd_pkg::A_DATA, 32'h5a);
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h1);
		wt(3);
		`CHK("kept in sleep", 1'b0, st.drained)
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h5);
		wt(1);
		`CHK("mode change", 1'b1, mode_change)
		wt(2);
		`CHK("cleared into rx", 1'b1, st.drained)
	endtask : t_clear
	task automatic t_rx;
		bus(1'b1, fsfd_pkg::A_PLIMIT, 32'h0);
		bus(1'b1, fsfd_pkg::A_PVAL_HI, 32'hd3a51122);
		bus(1'b1, fsfd_pkg::A_PVAL_LO, 32'h33445566);
		bus(1'b1, fsfd_pkg::A_PCFG, 32'h8);
		modem.run(64'h55d39c, 24);
		wt(8);
		`CHK("match", 1'b1, st.match)
		`CHK("byte stored", 1'b0, st.drained)
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h3);
		wt(3);
		`CHK("match cleared", 1'b0, st.match)
		bus(1'b0, fsfd_pkg::A_DATA, 32'h0);
		`CHK("rx byte", 8'h9c, rdata[7:0])
		wt(3);
		`CHK("drained", 1'b1, st.drained)
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h5);
		bus(1'b1, fsfd_pkg::A_PCFG, 32'h9);
		modem.run(64'h55d39c, 24);
		wt(8);
		`CHK("short match", 1'b0, st.match)
		modem.run(64'hd3a57e, 24);
		wt(8);
		`CHK("long match", 1'b1, st.match)
		bus(1'b0, fsfd_pkg::A_DATA, 32'h0);
		`CHK("rx byte 2", 8'h7e, rdata[7:0])
	endtask : t_rx
	task automatic t_tx;
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h3);
		bus(1'b1, fsfd_pkg::A_DATA, 32'hb2);
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h7);
		modem.run(64'h0, 64);
		wt(8);
		found = 1'b0;
		for (int k = 0; k <= 56; k++)
			if (modem.cap_r[k +: 8] === 8'hb2)
				found = 1'b1;
		`CHK("tx byte", 1'b1, found)
		`CHK("tx done", 1'b1, st.tx_done)
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h1);
		wt(3);
		`CHK("not settled", 1'b0, st.settled)
		tx_exit_done <= 1'b1;
		wt(5);
		`CHK("settled", 1'b1, st.settled)
		tx_exit_done <= 1'b0;
	endtask : t_tx
	task automatic t_cont;
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h4);
		wt(3);
		`CHK("pin driven", 1'b1, pin_oe)
		modem.run(64'hd3a5, 16);
		wt(8);
		`CHK("no lock", 1'b0, st.match)
		sync_lock <= 1'b1;
		modem.run(64'hd3a5, 16);
		wt(8);
		`CHK("locked match", 1'b1, st.match)
		`CHK("queue bypassed", 1'b1, st.drained)
		`CHK("pin data", 1'b1, pin_o)
		bus(1'b1, fsfd_pkg::A_CTRL, 32'h6);
		pin_in <= 1'b1;
		modem.run(64'h0, 2);
		wt(8);
		`CHK("pin to modulator", 1'b1, tx_bit)
	endtask : t_cont
	initial
	begin
		num_errors   = 0;
		compares     = 0;
		reset_n_i    = 1'b0;
		hsel         = 1'b0;
		haddr        = 32'h0;
		htrans       = 2'h0;
		hwrite       = 1'b0;
		hwdata       = 32'h0;
		sync_lock    = 1'b0;
		pin_in       = 1'b0;
		tx_exit_done = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_fill();
		t_clear();
		t_rx();
		t_tx();
		t_cont();
		conclude();
	end
	initial
	begin
		#400000;
		num_errors++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
